// file: dv/tgio_board_model.sv
/*
 * board side of the sixteen timer pins.
 * assumes the bench sets the level the board applies; a pin that the
 * device drives reads back the device's own level.
 */
`timescale 1ns/10ps
`default_nettype none

module tgio_board_model
(
    // device pin side
    input wire logic [15:0] tioOut,
    input wire logic [15:0] tioOe,
    // level the board puts on undriven pins
    input wire logic [15:0] boardLvl,
    // resolved pin level
    output logic [15:0] tioIn
);
    // ------------------------------------------------------------
    // wire resolution
    // ------------------------------------------------------------
    // the board is weak on every pin, so no pin ever floats; a
    // driven pin follows the device so no false edge reaches capture
    assign tioIn = (tioOe & tioOut) | (~tioOe & boardLvl);
endmodule
`default_nettype wire

// file: dv/tgio_io_control_chk.sv
/*
 * assertions on the apb answer, start/mode outputs and pin outputs
 * of tgio_io_control; sees only the top module's ports.
 * assumes one clock domain and a synchronous active-low reset.
 */
`timescale 1ns/10ps
`default_nettype none

module tgio_io_control_chk
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // timer core events
    input wire logic [5:0] cntClear,
    input wire logic [15:0] cmpMatch,
    // pins and state outputs
    input wire logic [15:0] tioOut,
    input wire logic [15:0] tioOe,
    input wire logic [5:0] counterStart,
    input wire logic [2:0] ch1ClockSel
);
    // ------------------------------------------------------------
    // helper terms
    // ------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // a write answered at this edge, refused ones included
    wire logic commit = psel && penable && pready && pwrite && ce;
    // anything allowed to move a pin level
    wire logic cause = commit || (|cmpMatch) || (|cntClear);

    sequence s_setup;
        psel && !penable && ce;
    endsequence
    sequence s_wr_at(logic [7:0] a);
        commit && paddr == a;
    endsequence

    // ------------------------------------------------------------
    // apb answer
    // ------------------------------------------------------------
    chk_ready_next: assert property (s_setup |=> pready)
        else $error("no answer after setup");
    chk_ready_pulse: assert property (pready && ce |=> !pready)
        else $error("ready longer than one cycle");
    chk_ready_acc: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    chk_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error answer not clean");
    chk_err_unmap: assert property (s_setup ##0
        (paddr > 8'h30 || paddr[1:0] != 2'h0) |=> pslverr)
        else $error("unmapped access not refused");

    // ------------------------------------------------------------
    // start and clock select follow their writes
    // ------------------------------------------------------------
    chk_start_wr: assert property (s_wr_at(tgio_pkg::OFS_START)
        ##0 pstrb[0] |=> counterStart == $past(pwdata[5:0]))
        else $error("start bits not updated");
    chk_clksel_wr: assert property (s_wr_at(tgio_pkg::OFS_MODE)
        ##0 pstrb[1] |=> ch1ClockSel == $past(pwdata[14:12]))
        else $error("clock select not updated");

    // ------------------------------------------------------------
    // pins only move for a reason
    // ------------------------------------------------------------
    chk_out_cause: assert property ($changed(tioOut) |->
        $past(cause) || $past(cause, 2) || $past(cause, 3))
        else $error("pin level moved without cause");
    chk_oe_cause: assert property ($changed(tioOe) |->
        $past(commit) || $past(commit, 2) || $past(commit, 3))
        else $error("pin enable moved without write");
endmodule

bind tgio_io_control tgio_io_control_chk u_chk
(
    .clock, .rst_b, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .cntClear, .cmpMatch,
    .tioOut, .tioOe, .counterStart, .ch1ClockSel
);
`default_nettype wire

// file: dv/tgio_io_control_tb_top.sv
/*
 * self-checking bench for tgio_io_control: apb tasks, timer events
 * and board pins driven from the bench.
 * assumes the register offsets and zero-wait apb answer of the design.
 */
`timescale 1ns/10ps
`default_nettype none

module tgio_io_control_tb_top;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clock, rst_b, ce, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [3:0] pstrb, c;
    logic [5:0][15:0] cntValue;
    logic [5:0] cntClear, counterStart;
    logic [15:0] cmpMatch, tioIn, tioOut, tioOe, boardLvl;
    logic ch1CountTick, err;
    logic [2:0] ch1ClockSel;
    int failCount, checked;

    tgio_io_control dut (.clock, .rst_b, .ce, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .cntValue,
        .cntClear, .cmpMatch, .ch1CountTick, .tioIn, .tioOut, .tioOe,
        .counterStart, .ch1ClockSel);
    tgio_board_model board (.tioOut, .tioOe, .boardLvl, .tioIn);

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failCount++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one transfer; request held until ready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // a slave that never answers is ended by the watchdog
        do
        begin
            @(posedge clock);
        end
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge so psel is never assigned twice in one step
        @(posedge clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rdat, err);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, rdat, err);
        check(rdat, exp);
    endtask
    // read one flag bit, then clear all flags
    task automatic flag(input int k, input logic exp);
        apb(1'b0, tgio_pkg::OFS_FLAGS, 32'h0, rdat, err);
        check(32'(rdat[k]), 32'(exp));
        wr(tgio_pkg::OFS_FLAGS, 32'hFFFF);
    endtask
    task automatic pin(input int k, input logic lvl);
        boardLvl[k] <= lvl;
        tick(10);
    endtask
    task automatic pulse(input logic [15:0] m, input logic [5:0] cl,
        input logic tk);
        cmpMatch <= m;
        cntClear <= cl;
        ch1CountTick <= tk;
        tick(1);
        cmpMatch <= 16'h0;
        cntClear <= 6'h0;
        ch1CountTick <= 1'b0;
        tick(4);
    endtask
    task automatic wrapUp();
        if (failCount == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // clock and watchdog
    // ------------------------------------------------------------
    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // the tests need a few hundred cycles; this is far beyond that
    initial
    begin
        tick(20000);
        failCount++;
        wrapUp();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        {rst_b, psel, penable, pwrite, ch1CountTick} = 5'h0;
        {paddr, pwdata, cntClear, cmpMatch, boardLvl} = '0;
        cntValue = '0;
        ce = 1'b1;
        pstrb = 4'hF;
        tick(20);
        rst_b <= 1'b1;
        tick(1);
        // reset values, refused accesses, byte placement
        for (int i = 0; i < 8; i++)
            rdc(8'(i * 4), 32'h0);
        apb(1'b1, 8'h01, 32'hFF, rdat, err);
        check(err, 1'b1);
        rdc(8'h00, 32'h0);
        apb(1'b0, 8'h34, 32'h0, rdat, err);
        check({err, rdat[30:0]}, 32'h80000000);
        for (int i = 0; i < 8; i++)
            wr(8'(i * 4), 32'hFFFFFF00 | 32'(i * 17 + 17));
        for (int i = 0; i < 8; i++)
            rdc(8'(i * 4), 32'(i * 17 + 17));
        wr(8'h00, 32'h0);
        wr(8'h14, 32'h0);
        wr(8'h0C, 32'h15);
        wr(8'h18, 32'h15);
        wr(8'h1C, 32'h51);
        tick(3);
        check({tioOut[11:8], tioOut[3:2]}, 6'h25);
        check({tioOe[11:8], tioOe[3:2]}, 6'h3F);
        wr(tgio_pkg::OFS_MODE, 32'h0F00);
        tick(3);
        check({tioOe[11:10], tioOe[3:2], tioOe[9:8]}, 6'h03);
        wr(tgio_pkg::OFS_MODE, 32'h0);
        for (int i = 0; i < 8; i++)
            wr(8'(i * 4), 32'h0);
        // every compare code on units A and B of channel 0
        for (int i = 0; i < 8; i++)
        begin
            c = 4'(i);
            wr(8'h00, {24'h0, c, c});
            tick(3);
            check(tioOe[1:0], (c[1:0] != 2'h0) ? 2'h3 : 2'h0);
            if (c[1:0] != 2'h0)
            begin
                check(tioOut[1:0], {2{c[2]}});
                wr(tgio_pkg::OFS_START, 32'h1);
                pulse(16'h0001, 6'h0, 1'b0);
                check(tioOut[1:0], {c[2], c[0] ? (c[1] & ~c[2]) : 1'b1});
                wr(tgio_pkg::OFS_START, 32'h0);
                tick(3);
                check(tioOut[0], c[2]);
            end
        end
        // pwm mode 2: clear restores the initial level
        wr(8'h00, 32'h05);
        wr(tgio_pkg::OFS_MODE, 32'h1);
        wr(tgio_pkg::OFS_START, 32'h1);
        pulse(16'h0001, 6'h0, 1'b0);
        check(tioOut[0], 1'b0);
        pulse(16'h0, 6'h01, 1'b0);
        check(tioOut[0], 1'b1);
        wr(tgio_pkg::OFS_MODE, 32'h0);
        // hand pin 0 back to the low board level so the first rising
        // capture sees a real edge; the compare flag is cleared here
        wr(8'h00, 32'h0);
        flag(0, 1'b1);
        // capture edge codes on unit A of channel 0
        for (int i = 8; i < 12; i++)
        begin
            c = 4'(i);
            cntValue[0] <= 16'hA500 + 16'(i);
            wr(8'h00, {28'h0, c});
            pin(0, 1'b1);
            flag(0, c != 4'h9);
            pin(0, 1'b0);
            flag(0, c != 4'h8);
        end
        wr(tgio_pkg::OFS_CAPSEL, 32'h0);
        rdc(tgio_pkg::OFS_CAPDATA, 32'hA50B);
        // unit B of channel 0 on channel 1 ticks
        cntValue[0] <= 16'h5A3C;
        wr(8'h00, 32'hC0);
        for (int i = 0; i < 2; i++)
        begin
            wr(tgio_pkg::OFS_MODE, 32'(1 - i) << 13);
            check(ch1ClockSel, 3'(2 - 2 * i));
            pulse(16'h0, 6'h0, 1'b1);
            flag(1, i == 0);
        end
        wr(tgio_pkg::OFS_CAPSEL, 32'h1);
        rdc(tgio_pkg::OFS_CAPDATA, 32'h5A3C);
        // buffered d register captures nothing
        wr(8'h18, 32'h80);
        for (int i = 0; i < 2; i++)
        begin
            wr(tgio_pkg::OFS_MODE, (i == 0) ? 32'h100 : 32'h0);
            pin(3, 1'b1);
            flag(3, i == 1);
            pin(3, 1'b0);
        end
        wrapUp();
    end
endmodule
`default_nettype wire

// file: rtl/tgio_io_control.sv
/*
 * general register i/o control for a six-channel timer: eight
 * function registers, start, mode and flag registers and the capture
 * store, reached over apb, plus sixteen pin units.
 * assumes the timer core supplies counter values, compare matches,
 * counter clears and the channel 1 count tick on the same clock.
 */
//
// Functional notes
// - initial level driven while counter stopped
// - pwm mode 2 drives initial level at clear
// - buffered c/d register ignores its function field
// - bits 7:4 select b, bits 3:0 a
// - channels 0,3 second register: d high, c low
// - eight function registers across six channels
// - codes 0000-0011 compare, initial level 0
// - codes 0100-0111 compare, initial level 1
// - low bits: 01 clear, 10 set, 11 toggle
// - code 1000 captures on rising pin edge
// - 1001 falling edge, 101x both edges
// - channel 0 b code 11xx captures on ch1 ticks
// - undivided ch1 clock makes that capture invalid
// - fields interpreted per channel mode setting
// - b/d buffer pair silences register d events
`timescale 1ns/10ps
`default_nettype none

module tgio_io_control
(
    // clock, reset, clock enable
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // timer core, per channel and per unit
    input wire logic [5:0][15:0] cntValue,
    input wire logic [5:0] cntClear,
    input wire logic [15:0] cmpMatch,
    input wire logic ch1CountTick,
    // timer pins, one per general register
    input wire logic [15:0] tioIn,
    output logic [15:0] tioOut,
    output logic [15:0] tioOe,
    // mode and start state to the timer core
    output logic [5:0] counterStart,
    output logic [2:0] ch1ClockSel
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0][7:0] ioCtrl;    // function registers
        logic [5:0] start;          // counter_start_bit per channel
        logic [14:0] mode;          // pwm2, buffer pairs, clock select
        logic [15:0] flags;         // capture/compare flags
        logic [3:0] capSel;         // capture store view index
        logic [15:0][15:0] cap;     // captured counter values
        logic [31:0] rdata;         // read data, loaded in setup
        logic ready;                // access phase answer
        logic slvErr;               // unmapped or misaligned
    } tgio_ctl_s;

    tgio_ctl_s q, d;
    logic [15:0] capStb;        // unit capture pulses
    logic [15:0] cmpStb;        // unit compare pulses
    logic [15:0][3:0] func;     // function nibble per unit
    logic setup;                // apb setup cycle
    logic wrEn;                 // write commits this edge
    logic [31:0] wmask;         // byte lane mask
    logic [31:0] wval;          // merged write value
    logic [31:0] cur;           // current value of addressed word

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------

    // a mapped, word-aligned offset
    function automatic logic addrOk(input logic [7:0] a);
        logic ok;
        ok = 1'b0;
        if (a[1:0] == 2'h0)
        begin
            if (a <= tgio_pkg::OFS_IOCTRL_END)
            begin
                ok = 1'b1;
            end
            else if (a >= tgio_pkg::OFS_START &&
                     a <= tgio_pkg::OFS_CAPDATA)
            begin
                ok = 1'b1;
            end
        end
        return ok;
    endfunction

    // value held at a word offset, zero where nothing is mapped
    function automatic logic [31:0] wordOf(input tgio_ctl_s s,
                                           input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (a <= tgio_pkg::OFS_IOCTRL_END)
        begin
            v = {24'h00_0000, s.ioCtrl[a[4:2]]};
        end
        else
        begin
            case (a)
                tgio_pkg::OFS_START: v = {26'h000_0000, s.start};
                tgio_pkg::OFS_MODE: v = {17'h0_0000, s.mode};
                tgio_pkg::OFS_FLAGS: v = {16'h0000, s.flags};
                tgio_pkg::OFS_CAPSEL: v = {28'h000_0000, s.capSel};
                tgio_pkg::OFS_CAPDATA: v = {16'h0000, s.cap[s.capSel]};
                default: v = 32'h0000_0000;
            endcase
        end
        return v;
    endfunction

    // buffer mode of a unit: only c and d of channels 0 and 3 pair up
    function automatic logic bufOf(input logic [14:0] m, input int k);
        logic b;
        case (k)
            tgio_pkg::UNIT_CH0_C: b = m[tgio_pkg::MODE_BUFAC0];
            tgio_pkg::UNIT_CH0_D: b = m[tgio_pkg::MODE_BUFBD0];
            tgio_pkg::UNIT_CH3_C: b = m[tgio_pkg::MODE_BUFAC3];
            tgio_pkg::UNIT_CH3_D: b = m[tgio_pkg::MODE_BUFBD3];
            default: b = 1'b0;
        endcase
        return b;
    endfunction

    // ------------------------------------------------------------------
    // pin units
    // ------------------------------------------------------------------

    // capture on channel 1 ticks is dead when it counts the raw clock
    logic ch1TickOk;
    assign ch1TickOk = (q.mode[tgio_pkg::MODE_CLKSEL_LSB +: 3] !=
                        tgio_pkg::CLKSEL_UNDIVIDED);

    genvar k;
    generate
        for (k = 0; k < 16; k++)
        begin : gUnit
            localparam int CH = int'(tgio_pkg::UNIT_CH[k]);
            localparam int RG = int'(tgio_pkg::UNIT_REG[k]);
            // upper nibble is b or d, lower is a or c
            assign func[k] = tgio_pkg::UNIT_HI[k] ?
                q.ioCtrl[RG][tgio_pkg::FUNC_HI_MSB:tgio_pkg::FUNC_HI_LSB] :
                q.ioCtrl[RG][tgio_pkg::FUNC_LO_MSB:tgio_pkg::FUNC_LO_LSB];
            tgio_pin_unit uUnit
            (
                .clock(clock),
                .rst_b(rst_b),
                .ce(ce),
                .func(func[k]),
                .running(q.start[CH]),
                .pwm2(q.mode[tgio_pkg::MODE_PWM2_LSB + CH]),
                .bufMode(bufOf(q.mode, k)),
                .altOk((k == tgio_pkg::UNIT_CH0_B) && ch1TickOk),
                .cntClear(cntClear[CH]),
                .cmpMatch(cmpMatch[k]),
                .altTick(ch1CountTick),
                .pinIn(tioIn[k]),
                .pinOut(tioOut[k]),
                .pinOe(tioOe[k]),
                .capStb(capStb[k]),
                .cmpStb(cmpStb[k])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // register file next state
    // ------------------------------------------------------------------

    // one wait-free access: answer prepared in the setup cycle so the
    // outputs stay on flip-flops without costing a wait state
    always_comb
    begin
        d = q;
        setup = psel & ~penable;
        wrEn = psel & penable & q.ready & pwrite & ~q.slvErr;
        wmask = {{8{pstrb[3]}}, {8{pstrb[2]}},
                 {8{pstrb[1]}}, {8{pstrb[0]}}};
        cur = wordOf(q, paddr);
        wval = (cur & ~wmask) | (pwdata & wmask);

        // answer: ready for exactly the access cycle
        d.ready = setup;
        d.slvErr = setup & ~addrOk(paddr);
        if (setup)
        begin
            // a refused read answers zero, not a neighbouring word
            d.rdata = (pwrite || !addrOk(paddr)) ? 32'h0000_0000 : cur;
        end

        // software writes; flags write-one-to-clear
        if (wrEn)
        begin
            if (paddr <= tgio_pkg::OFS_IOCTRL_END)
            begin
                d.ioCtrl[paddr[4:2]] = wval[7:0];
            end
            else
            begin
                case (paddr)
                    tgio_pkg::OFS_START: d.start = wval[5:0];
                    tgio_pkg::OFS_MODE: d.mode = wval[14:0];
                    tgio_pkg::OFS_FLAGS:
                        d.flags = q.flags & ~(pwdata[15:0] & wmask[15:0]);
                    tgio_pkg::OFS_CAPSEL: d.capSel = wval[3:0];
                    default: d.capSel = q.capSel;       // read-only view
                endcase
            end
        end

        // events: a set in the clearing cycle still wins
        d.flags = d.flags | capStb | cmpStb;

        // capture copies its channel's counter
        for (int i = 0; i < 16; i++)
        begin
            if (capStb[i])
            begin
                d.cap[i] = cntValue[tgio_pkg::UNIT_CH[i]];
            end
        end
    end

    // ------------------------------------------------------------------
    // state register, frozen while ce is low
    // ------------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            q.ioCtrl <= {8{tgio_pkg::RST_IOCTRL}};
            q.start <= tgio_pkg::RST_START;
            q.mode <= tgio_pkg::RST_MODE;
            q.flags <= tgio_pkg::RST_FLAGS;
            q.capSel <= 4'h0;
            q.cap <= '0;
            q.rdata <= 32'h0000_0000;
            q.ready <= 1'b0;
            q.slvErr <= 1'b0;
        end
        else if (ce)
        begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign prdata = q.rdata;
    assign pready = q.ready;
    assign pslverr = q.slvErr;
    assign counterStart = q.start;
    assign ch1ClockSel = q.mode[tgio_pkg::MODE_CLKSEL_LSB +: 3];

endmodule

`default_nettype wire

// file: rtl/tgio_pin_unit.sv
/*
 * one general register's pin and event logic: output compare level,
 * or input capture edge detection, as chosen by its 4-bit function.
 * assumes compare match, counter clear and tick come from the timer
 * core on the same clock; the pin input is asynchronous.
 */
`timescale 1ns/10ps
`default_nettype none

module tgio_pin_unit
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ce,
    // configuration
    input wire logic [3:0] func,
    input wire logic running,
    input wire logic pwm2,
    input wire logic bufMode,
    input wire logic altOk,
    // timer core events
    input wire logic cntClear,
    input wire logic cmpMatch,
    input wire logic altTick,
    // pin
    input wire logic pinIn,
    output logic pinOut,
    output logic pinOe,
    // events to the register file
    output logic capStb,
    output logic cmpStb
);

    typedef struct packed {
        logic [2:0] sync;   // pin synchroniser, bit 0 first
        logic filt;         // settled pin level
        logic pin;          // driven pin level
        logic oe;           // pin drive enable
        logic cap;          // capture pulse
        logic cmp;          // compare pulse
    } tgio_unit_s;

    tgio_unit_s q, d;
    logic newFilt;      // settled level after this edge
    logic trig;         // selected capture trigger
    logic isCap;        // function is input capture

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        d = q;
        d.sync = {q.sync[1:0], pinIn};
        // change counts only once second and third stage agree
        newFilt = (q.sync[1] == q.sync[2]) ? q.sync[2] : q.filt;
        d.filt = newFilt;
        isCap = func[3];
        // capture source by code
        case (func[2:0])
            3'h0: trig = newFilt & ~q.filt;
            3'h1: trig = ~newFilt & q.filt;
            3'h2, 3'h3: trig = newFilt ^ q.filt;
            default: trig = altTick & altOk;
        endcase
        // a buffer register drives nothing and raises nothing
        d.oe = ~bufMode & ~isCap & (func[1:0] != 2'h0);
        if (!running || (pwm2 && cntClear))
        begin
            d.pin = func[2];
        end
        else if (cmpMatch && !isCap && !bufMode)
        begin
            case (func[1:0])
                2'h1: d.pin = 1'b0;
                2'h2: d.pin = 1'b1;
                2'h3: d.pin = ~q.pin;
                default: d.pin = q.pin;                 // output disabled
            endcase
        end
        d.cap = isCap & ~bufMode & running & trig;
        d.cmp = ~isCap & ~bufMode & running & cmpMatch;
    end

    // ------------------------------------------------------------------
    // state register, frozen while ce is low
    // ------------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            q <= '0;
        end
        else if (ce)
        begin
            q <= d;
        end
    end

    assign pinOut = q.pin;
    assign pinOe = q.oe;
    assign capStb = q.cap;
    assign cmpStb = q.cmp;

endmodule

`default_nettype wire

// file: shared/tgio_pkg.sv
/*
 * shared constants for the timer general register i/o control block:
 * register byte offsets, field layout, reset values and the map from
 * general register unit to its control register, nibble and channel.
 * assumes a 32-bit apb slave with one register per aligned word.
 */
package tgio_pkg;

    // ------------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_IOCTRL_BASE = 8'h00; // eight control bytes
    localparam logic [7:0] OFS_IOCTRL_END = 8'h1C;  // last control byte
    localparam logic [7:0] OFS_START = 8'h20;       // counter start bits
    localparam logic [7:0] OFS_MODE = 8'h24;        // mode / buffer / clock
    localparam logic [7:0] OFS_FLAGS = 8'h28;       // capture/compare flags
    localparam logic [7:0] OFS_CAPSEL = 8'h2C;      // capture view index
    localparam logic [7:0] OFS_CAPDATA = 8'h30;     // captured value view

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int FUNC_HI_MSB = 7;     // register B or D function
    localparam int FUNC_HI_LSB = 4;
    localparam int FUNC_LO_MSB = 3;     // register A or C function
    localparam int FUNC_LO_LSB = 0;
    localparam int MODE_PWM2_LSB = 0;   // one bit per channel, 5:0
    localparam int MODE_BUFBD0 = 8;     // buffer_pair_bd, channel 0
    localparam int MODE_BUFBD3 = 9;     // buffer_pair_bd, channel 3
    localparam int MODE_BUFAC0 = 10;    // a/c buffer pair, channel 0
    localparam int MODE_BUFAC3 = 11;    // a/c buffer pair, channel 3
    localparam int MODE_CLKSEL_LSB = 12; // clock_select_field of ch 1

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_IOCTRL = 8'h00;
    localparam logic [5:0] RST_START = 6'h00;
    localparam logic [14:0] RST_MODE = 15'h0000;
    localparam logic [15:0] RST_FLAGS = 16'h0000;
    localparam logic [2:0] CLKSEL_UNDIVIDED = 3'h0; // counts on raw clock

    // ------------------------------------------------------------------
    // unit map: A,B,C,D of ch0, A,B of ch1, ch2, A..D of ch3, ch4, ch5
    // ------------------------------------------------------------------
    localparam logic [15:0][2:0] UNIT_REG = {
        3'h5, 3'h5, 3'h4, 3'h4, 3'h7, 3'h7, 3'h3, 3'h3,
        3'h2, 3'h2, 3'h1, 3'h1, 3'h6, 3'h6, 3'h0, 3'h0};
    localparam logic [15:0][2:0] UNIT_CH = {
        3'h5, 3'h5, 3'h4, 3'h4, 3'h3, 3'h3, 3'h3, 3'h3,
        3'h2, 3'h2, 3'h1, 3'h1, 3'h0, 3'h0, 3'h0, 3'h0};
    localparam logic [15:0] UNIT_HI = 16'hAAAA; // odd units use bits 7:4
    localparam int UNIT_CH0_B = 1;  // may capture on channel 1 ticks
    localparam int UNIT_CH0_C = 2;
    localparam int UNIT_CH0_D = 3;
    localparam int UNIT_CH3_C = 10;
    localparam int UNIT_CH3_D = 11;

endpackage
